// ### fbc_ctrl.sv
// flash bus controller top: AXI4-Lite registers in, flash pins out
// assumes synchronous flash pins, ready_busy_n pulled up
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "fbc_map.svh"
module fbc_ctrl #(
    parameter int AW      = 20,
    parameter int DW      = 16,
    parameter int RST_CYC = `FBC_RESET_CYC
) (
    input  wire logic          clk_sys,          // clock
    input  wire logic          rst_n,            // reset, low
    input  wire logic [7:0]    s_axi_awaddr,     // aw addr
    input  wire logic          s_axi_awvalid,    // aw valid
    output logic               s_axi_awready,    // aw ready
    input  wire logic [31:0]   s_axi_wdata,      // w data
    input  wire logic [3:0]    s_axi_wstrb,      // w strobes
    input  wire logic          s_axi_wvalid,     // w valid
    output logic               s_axi_wready,     // w ready
    output logic [1:0]         s_axi_bresp,      // b resp
    output logic               s_axi_bvalid,     // b valid
    input  wire logic          s_axi_bready,     // b ready
    input  wire logic [7:0]    s_axi_araddr,     // ar addr
    input  wire logic          s_axi_arvalid,    // ar valid
    output logic               s_axi_arready,    // ar ready
    output logic [31:0]        s_axi_rdata,      // r data
    output logic [1:0]         s_axi_rresp,      // r resp
    output logic               s_axi_rvalid,     // r valid
    input  wire logic          s_axi_rready,     // r ready
    output logic               chip_sel_n,       // chip select
    output logic               out_en_n,         // output enable
    output logic               write_en_n,       // write strobe
    output logic               reset_powerdown_n,// device reset
    output logic               byte_wide,        // high: 16 bit
    output logic               write_protect_n,  // low locks
    output logic [AW-1:0]      flash_addr,       // address pins
    input  wire logic [DW-1:0] flash_dq_in,      // data in
    output logic [DW-1:0]      flash_dq_out,     // data out
    output logic               flash_dq_oe_n,    // low drives
    input  wire logic          ready_busy_n      // low when busy
);
    import fbc_pkg::*;

    fbc_cyc_if #(.AW(AW), .DW(DW)) cyc_bus ();

    typedef enum logic [2:0] {S_IDLE, S_RESET, S_FIRST, S_SECOND, S_REPLY} fbc_seq_t;
    fbc_seq_t seq_q;

    // software-visible state and the reset counter
    logic [31:0]   ctrl_q;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] wdata_q;
    logic [DW-1:0] rdata_q;
    fbc_op_t       op_q;
    logic [7:0]    aux_q;   // cmd data field, only read back; lock second codes come from op_q
    logic          busy_q;
    logic          err_q;
    logic [7:0]    rst_cnt_q;

    // bus slave holding state
    logic          aw_got_q, w_got_q;
    logic [7:0]    aw_q;
    logic [31:0]   w_q;
    logic [3:0]    ws_q;

    // request to the pin engine
    logic          req_q;
    fbc_cyc_t      kind_q;
    logic [AW-1:0] caddr_q;
    logic [DW-1:0] cdata_q;

    assign cyc_bus.req   = req_q;
    assign cyc_bus.kind  = kind_q;
    assign cyc_bus.addr  = caddr_q;
    assign cyc_bus.wdata = cdata_q;

    // first code of each operation; 40H used for program, 10H equally valid
    // only defined codes issued
    function automatic logic [7:0] first_code(input fbc_op_t op);
        unique case (op)
            FBC_OP_READ_ARRAY:  first_code = `FBC_C_READ_ARRAY;
            FBC_OP_READ_ID:     first_code = `FBC_C_READ_ID;
            FBC_OP_READ_STAT:   first_code = `FBC_C_READ_STAT;
            FBC_OP_CLR_STAT:    first_code = `FBC_C_CLR_STAT;
            FBC_OP_BLOCK_ERASE: first_code = `FBC_C_ERASE_SU;
            FBC_OP_CHIP_ERASE:  first_code = `FBC_C_CHIP_SU;
            FBC_OP_PROGRAM:     first_code = `FBC_C_PROG_SU;
            FBC_OP_SUSPEND:     first_code = `FBC_C_SUSPEND;
            FBC_OP_RESUME:      first_code = `FBC_C_CONFIRM;
            FBC_OP_LOCK_SET,
            FBC_OP_LOCK_CLR,
            FBC_OP_PERM_SET:    first_code = `FBC_C_LOCK_SU;
            default:            first_code = `FBC_C_READ_ARRAY;
        endcase
    endfunction

    // merge AXI byte lanes into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    endfunction

    // operation decode
    wire fbc_op_t cmd_op    = fbc_op_t'(w_q[`FBC_CMD_OP_MSB:`FBC_CMD_OP_LSB]);
    wire          op_legal  = (w_q[`FBC_CMD_OP_MSB:`FBC_CMD_OP_LSB] <= 4'(FBC_OP_READ));
    wire          two_write = op_q inside {FBC_OP_BLOCK_ERASE, FBC_OP_CHIP_ERASE,
                              FBC_OP_PROGRAM, FBC_OP_LOCK_SET,
                              FBC_OP_LOCK_CLR, FBC_OP_PERM_SET};
    wire          one_read  = (op_q == FBC_OP_READ);
    // erase confirm; lock second code; program value
    wire [7:0]    sec_code  = (op_q == FBC_OP_LOCK_SET) ? `FBC_C_LOCK_SET :
                              (op_q == FBC_OP_PERM_SET) ? `FBC_C_PERM_SET : `FBC_C_CONFIRM;
    wire [DW-1:0] sec_data  = (op_q == FBC_OP_PROGRAM) ? wdata_q : DW'(sec_code);

    // write channel decode
    wire wr_fire   = aw_got_q && w_got_q && !s_axi_bvalid;
    wire wr_cmd    = wr_fire && (aw_q == `FBC_OFF_CMD);
    wire cmd_ok    = wr_cmd && (seq_q == S_IDLE) && op_legal;
    wire wr_known  = aw_q inside {`FBC_OFF_CMD, `FBC_OFF_ADDR,
                     `FBC_OFF_WDATA, `FBC_OFF_CTRL};

    // AXI write address and data capture, either order
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            aw_q     <= 8'h00;
            w_q      <= 32'h0000_0000;
            ws_q     <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_q     <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_fire)
                aw_got_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                w_q     <= s_axi_wdata;
                ws_q    <= s_axi_wstrb;
            end else if (wr_fire)
                w_got_q <= 1'b0;
        end
    end

    // write response; a command while busy or an illegal op answers SLVERR
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awready <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wready <= 1'b0;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (!wr_known || (wr_cmd && !cmd_ok)) ? 2'b10 : 2'b00;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // register writes
    // byte select from ctrl; write-protect from ctrl
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= `FBC_CTRL_RST;
            addr_q  <= '0;
            wdata_q <= '0;
        end else if (wr_fire) begin
            if (aw_q == `FBC_OFF_CTRL)
                ctrl_q <= merge(ctrl_q, w_q, ws_q);
            if (aw_q == `FBC_OFF_ADDR)
                addr_q <= AW'(merge(32'(addr_q), w_q, ws_q));
            if (aw_q == `FBC_OFF_WDATA)
                wdata_q <= DW'(merge(32'(wdata_q), w_q, ws_q));
        end
    end

    // read channel
    wire [31:0] status_word = {29'h0, err_q, ready_busy_n, busy_q};
    wire [7:0]  ra = {s_axi_araddr[7:2], 2'b00};
    wire [31:0] rd_mux =
        (ra == `FBC_OFF_CMD)    ? {20'h0, aux_q, 4'(op_q)} :
        (ra == `FBC_OFF_ADDR)   ? 32'(addr_q) :
        (ra == `FBC_OFF_WDATA)  ? 32'(wdata_q) :
        (ra == `FBC_OFF_STATUS) ? status_word :
        (ra == `FBC_OFF_RDATA)  ? 32'(rdata_q) :
        (ra == `FBC_OFF_CTRL)   ? ctrl_q : 32'h0000_0000;
    wire rd_known = (ra <= `FBC_OFF_CTRL);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_known ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // sequencer: one or two writes, or one read, per op
    // reset pulse runs first, and again whenever ctrl reset bit is written 0 while idle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seq_q     <= S_RESET;
            op_q      <= FBC_OP_READ_ARRAY;
            aux_q     <= 8'h00;
            busy_q    <= 1'b1;
            err_q     <= 1'b0;
            rst_cnt_q <= 8'h00;
            req_q     <= 1'b0;
            kind_q    <= FBC_CYC_WRITE;
            caddr_q   <= '0;
            cdata_q   <= '0;
            rdata_q   <= '0;
            reset_powerdown_n <= 1'b0;
        end else begin
            req_q <= 1'b0;
            if (wr_cmd && !cmd_ok)
                err_q <= 1'b1;
            unique case (seq_q)
                // reset held low RST_CYC cycles after power-on, one cycle fewer after a ctrl reset
                S_RESET: begin
                    reset_powerdown_n <= 1'b0;
                    rst_cnt_q <= rst_cnt_q + 8'h01;
                    if (rst_cnt_q == 8'(RST_CYC - 1)) begin
                        reset_powerdown_n <= 1'b1;
                        rst_cnt_q <= 8'h00;
                        busy_q    <= 1'b0;
                        seq_q     <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (wr_fire && aw_q == `FBC_OFF_CTRL && ws_q[0] &&
                        !w_q[`FBC_CTRL_RESET_BIT]) begin
                        busy_q <= 1'b1;
                        seq_q  <= S_RESET;
                    end else if (cmd_ok) begin
                        op_q    <= cmd_op;
                        aux_q   <= w_q[`FBC_CMD_DATA_MSB:`FBC_CMD_DATA_LSB];
                        busy_q  <= 1'b1;
                        err_q   <= 1'b0;
                        req_q   <= 1'b1;
                        caddr_q <= addr_q;
                        kind_q  <= (cmd_op == FBC_OP_READ) ? FBC_CYC_READ : FBC_CYC_WRITE;
                        cdata_q <= DW'(first_code(cmd_op));
                        seq_q   <= S_FIRST;
                    end
                end
                S_FIRST: if (cyc_bus.done) begin
                    if (one_read)
                        rdata_q <= cyc_bus.rdata;
                    if (two_write) begin
                        req_q   <= 1'b1;
                        kind_q  <= FBC_CYC_WRITE;
                        caddr_q <= addr_q;
                        cdata_q <= sec_data;
                        seq_q   <= S_SECOND;
                    end else
                        seq_q <= S_REPLY;
                end
                S_SECOND: if (cyc_bus.done)
                    seq_q <= S_REPLY;
                S_REPLY: begin
                    busy_q <= 1'b0;
                    seq_q  <= S_IDLE;
                end
                default: seq_q <= S_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byte_wide       <= 1'b1;
            write_protect_n <= 1'b1;
        end else begin
            byte_wide       <= ctrl_q[`FBC_CTRL_WIDE_BIT];
            write_protect_n <= ctrl_q[`FBC_CTRL_WP_BIT];
        end
    end

    fbc_pin_engine #(.AW(AW), .DW(DW)) u_eng (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .cyc     (cyc_bus),
        .wide    (ctrl_q[`FBC_CTRL_WIDE_BIT]),
        .dq_in   (flash_dq_in),
        .ce_n    (chip_sel_n),
        .oe_n    (out_en_n),
        .we_n    (write_en_n),
        .a_out   (flash_addr),
        .dq_out  (flash_dq_out),
        .dq_oe_n (flash_dq_oe_n)
    );
endmodule

// ### fbc_ctrl_assertions.sv
// pin-level checker for the flash bus controller
// assumes binding into fbc_ctrl, one clock domain
`timescale 1ns/1ps
module fbc_ctrl_assertions #(parameter int RST_CYC = 13) (
    input wire logic clk_sys,           // clock
    input wire logic rst_n,             // async reset, low
    input wire logic chip_sel_n,        // chip select
    input wire logic out_en_n,          // output enable
    input wire logic write_en_n,        // write strobe
    input wire logic reset_powerdown_n, // device reset
    input wire logic flash_dq_oe_n      // data drive, low drives
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [4:0] low_q;
    // device reset length, saturating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) low_q <= 5'h00;
        else low_q <= reset_powerdown_n ? 5'h00 : low_q + {4'h0, low_q != 5'h1F};
    end
    a_no_oe_we: assert property (!(!out_en_n && !write_en_n))
        else $error("oe and we low");
    a_write_drives: assert property (!write_en_n |-> !chip_sel_n && !flash_dq_oe_n && out_en_n)
        else $error("write without drive");
    a_read_floats: assert property (!out_en_n |-> flash_dq_oe_n && !chip_sel_n)
        else $error("read cycle while driving data");
    a_we_rises_first: assert property ($rose(write_en_n) |-> !chip_sel_n)
        else $error("ce rose first");
    a_strobe_width: assert property ($fell(write_en_n) |-> !write_en_n [*7] ##1 write_en_n)
        else $error("write strobe width wrong");
    a_select_first: assert property ($fell(chip_sel_n) |-> write_en_n && out_en_n)
        else $error("strobe fell with chip select");
    a_reset_quiet: assert property (!reset_powerdown_n |-> chip_sel_n && write_en_n && out_en_n)
        else $error("cycle in reset");
    a_reset_long: assert property ($rose(reset_powerdown_n) |-> low_q >= RST_CYC - 1)
        else $error("reset too short");
    c_write: cover property ($fell(write_en_n));
    c_read: cover property ($fell(out_en_n));
    c_wake: cover property ($rose(reset_powerdown_n));
endmodule
bind fbc_ctrl fbc_ctrl_assertions #(.RST_CYC(RST_CYC)) u_chk (.clk_sys, .rst_n, .chip_sel_n,
    .out_en_n, .write_en_n, .reset_powerdown_n, .flash_dq_oe_n);

// ### fbc_ctrl_tb_top.sv
// bench: AXI4-Lite orders, device model on pins
// assumes fbc_pkg compiled first, 125 MHz clock
`timescale 1ns/1ps
module fbc_ctrl_tb_top;
    import fbc_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, r;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, chip_sel_n;
    logic out_en_n, write_en_n, reset_powerdown_n, byte_wide, write_protect_n, flash_dq_oe_n;
    logic ready_busy_n;
    logic [19:0] flash_addr;
    logic [15:0] flash_dq_out, mq, dq;
    int n_mismatch = 0, samples_checked = 0;
    always #4 clk_sys = ~clk_sys;
    // wire level: whoever drives
    assign dq = flash_dq_oe_n ? mq : flash_dq_out;
    fbc_ctrl uut (.*, .flash_dq_in(dq));
    fbc_flash_model dev (.*);
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tmo;
        n_mismatch++;
        $display("CHECK FAILED %0t wait timed out", $time);
        close_out();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer; bready/rready held to the answer
    task automatic acc(input bit wr, input logic [7:0] ad, input logic [31:0] wd);
        int n = 0;
        if (wr) begin
            s_axi_awaddr <= ad; s_axi_wdata <= wd; s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= ad; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        end
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 300);
        r = s_axi_rdata;
        rs = wr ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n >= 300) tmo();
        @(posedge clk_sys);
    endtask
    // poll until idle and ready
    task automatic idle;
        int k = 0;
        do begin acc(0, 8'h0C, 0); k++; end while (r[1:0] !== 2'b10 && k < 300);
        if (k >= 300) tmo();
    endtask
    task automatic cmd(input fbc_op_t op); acc(1, 8'h00, 32'(op)); idle(); endtask
    task automatic fr(input logic [19:0] ad); acc(1, 8'h04, 32'(ad)); cmd(FBC_OP_READ); acc(0, 8'h10, 0); endtask
    task automatic stat; cmd(FBC_OP_READ_STAT); fr(20'h00000); endtask
    task automatic at(input logic [19:0] ad); acc(1, 8'h04, 32'(ad)); endtask
    task automatic t_reset;
        acc(0, 8'h14, 0); chk(r, 32'h0000_0007);
        stat(); chk(r, 32'h0000_0080);
        acc(0, 8'h40, 0); chk(32'(rs), 32'h0000_0002);
        acc(1, 8'h00, 32'h0000_000F); chk(32'(rs), 32'h0000_0002);
        acc(0, 8'h0C, 0); chk(r, 32'h0000_0006);
        $display("test reset done");
    endtask
    task automatic t_prog;
        acc(1, 8'h08, 32'h0000_1234); at(20'h00100); cmd(FBC_OP_PROGRAM);
        cmd(FBC_OP_READ_ARRAY); fr(20'h00100); chk(r, 32'h0000_1234);
        acc(1, 8'h14, 32'h0000_0005); fr(20'h00100); chk(r, 32'h0000_0034);
        acc(1, 8'h14, 32'h0000_0007);
        $display("test program done");
    endtask
    task automatic t_lock;
        at(20'h10000); cmd(FBC_OP_LOCK_SET); cmd(FBC_OP_READ_ID);
        fr(20'h10002); chk(r, 32'h0000_0001);
        at(20'h10000); cmd(FBC_OP_BLOCK_ERASE); stat(); chk(r, 32'h0000_00A2);
        cmd(FBC_OP_CLR_STAT); stat(); chk(r, 32'h0000_0080);
        acc(1, 8'h14, 32'h0000_0003); at(20'hF0000); cmd(FBC_OP_BLOCK_ERASE);
        stat(); chk(r, 32'h0000_00A2);
        cmd(FBC_OP_CLR_STAT); acc(1, 8'h14, 32'h0000_0007);
        $display("test lock done");
    endtask
    task automatic t_perm;
        cmd(FBC_OP_PERM_SET); cmd(FBC_OP_LOCK_CLR); cmd(FBC_OP_READ_ID);
        fr(20'h10002); chk(r, 32'h0000_0001);
        fr(20'h00003); chk(r, 32'h0000_0001);
        cmd(FBC_OP_CLR_STAT); cmd(FBC_OP_CHIP_ERASE); stat(); chk(r, 32'h0000_0080);
        $display("test permanent lock done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        idle();
        t_reset();
        t_prog();
        t_lock();
        t_perm();
        close_out();
    end
endmodule

// ### fbc_cyc_if.sv
// sequencer to pin engine bundle
// assumes one clock domain
`timescale 1ns/1ps
interface fbc_cyc_if #(parameter int AW = 20, parameter int DW = 16);
    logic                 req;   // start one bus cycle
    fbc_pkg::fbc_cyc_t    kind;  // read or write
    logic [AW-1:0]        addr;  // cycle address
    logic [DW-1:0]        wdata; // write value
    logic                 done;  // one-cycle end pulse
    logic [DW-1:0]        rdata; // captured read value
    modport seq (output req, kind, addr, wdata, input done, rdata);
    modport eng (input req, kind, addr, wdata, output done, rdata);
endinterface

// ### fbc_flash_model.sv
// flash device model: commands, status, locks, id codes
// assumes a pull-up on ready/busy
`timescale 1ns/1ps
module fbc_flash_model #(
    parameter logic [15:0] MFR = 16'h005A, // arbitrary maker code
    parameter logic [15:0] DEV = 16'h00C3  // arbitrary device code
) (
    input  wire logic        reset_powerdown_n, // device reset
    input  wire logic        chip_sel_n,        // select
    input  wire logic        out_en_n,          // output enable
    input  wire logic        write_en_n,        // write strobe
    input  wire logic        write_protect_n,   // boot protect
    input  wire logic        byte_wide,         // 16-bit bus
    input  wire logic [19:0] flash_addr,        // address
    input  wire logic [15:0] dq,                // data wire level
    output logic      [15:0] mq,                // driven data or float pattern
    output logic             ready_busy_n       // low while busy
);
    logic [7:0] prev, sr;
    logic [1:0] mode;
    logic [15:0] lk = 16'h0000, v;
    logic [15:0] mem [int];
    logic perm = 1'b0, busy = 1'b0, two, drv, prot;
    // boot block also locked by wp
    assign prot = lk[flash_addr[19:16]] || (flash_addr[19:16] == 4'hF && !write_protect_n);
    assign ready_busy_n = !busy;
    assign drv = reset_powerdown_n && !chip_sel_n && !out_en_n && write_en_n;
    assign mq = drv ? (byte_wide ? v : {~v[15:8], v[7:0]}) : ~v;
    always @* begin
        if (mode == 2'd2) v = {8'h00, sr | {!busy, 7'h00}};
        else if (mode == 2'd0) v = mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 16'hFFFF;
        else case (flash_addr[1:0])
            2'd0: v = MFR;
            2'd1: v = DEV;
            2'd2: v = {15'h0000, lk[flash_addr[19:16]]};
            default: v = {15'h0000, perm};
        endcase
    end
    // wake in array read with status 80h
    always @(negedge reset_powerdown_n) begin
        mode = 2'd0;
        sr = 8'h00;
        prev = 8'h00;
        busy = 1'b0;
    end
    task automatic run;
        busy = 1'b1;
        busy <= #400 1'b0;
    endtask
    // latch on the strobe rising first
    always @(posedge write_en_n) if (reset_powerdown_n && !chip_sel_n && out_en_n) begin
        two = 1'b1;
        case (prev)
            // erase confirm, refused on a protected block
            8'h20: if (prot) sr |= 8'h22; else run();
            8'h30: begin mem.delete(); run(); end
            // second write carries location and value
            8'h40, 8'h10: if (prot) sr |= 8'h12; else begin mem[int'(flash_addr)] = dq; run(); end
            8'h60: if (perm) sr |= 8'h12; else begin
                if (dq[7:0] == 8'h01) lk[flash_addr[19:16]] = 1'b1;
                if (dq[7:0] == 8'hD0) lk = 16'h0000;
                if (dq[7:0] == 8'hF1) perm = 1'b1;
                run();
            end
            // single-cycle codes; flags clear only on 50h or on device reset
            default: begin
                two = 1'b0;
                if (dq[7:0] == 8'hFF) mode = 2'd0;
                if (dq[7:0] == 8'h90) mode = 2'd1;
                if (dq[7:0] == 8'h70) mode = 2'd2;
                if (dq[7:0] == 8'h50) sr = 8'h00;
            end
        endcase
        if (two) mode = 2'd2;
        prev = two ? 8'h00 : dq[7:0];
    end
endmodule

// ### fbc_map.svh
// offsets, fields, command codes, timing counts
// assumes inclusion by bare name
`ifndef FBC_MAP_SVH
`define FBC_MAP_SVH
// register offsets
`define FBC_OFF_CMD      8'h00
`define FBC_OFF_ADDR     8'h04
`define FBC_OFF_WDATA    8'h08
`define FBC_OFF_STATUS   8'h0C
`define FBC_OFF_RDATA    8'h10
`define FBC_OFF_CTRL     8'h14
// cmd fields
`define FBC_CMD_OP_LSB   0
`define FBC_CMD_OP_MSB   3
`define FBC_CMD_DATA_LSB 8
`define FBC_CMD_DATA_MSB 15
// ctrl fields
`define FBC_CTRL_RESET_BIT 0
`define FBC_CTRL_WIDE_BIT  1
`define FBC_CTRL_WP_BIT    2
`define FBC_CTRL_RST       32'h0000_0007
// device command codes
`define FBC_C_READ_ARRAY 8'hFF
`define FBC_C_READ_ID    8'h90
`define FBC_C_READ_STAT  8'h70
`define FBC_C_CLR_STAT   8'h50
`define FBC_C_ERASE_SU   8'h20
`define FBC_C_CHIP_SU    8'h30
`define FBC_C_CONFIRM    8'hD0
`define FBC_C_PROG_SU    8'h40
`define FBC_C_PROG_ALT   8'h10
`define FBC_C_SUSPEND    8'hB0
`define FBC_C_LOCK_SU    8'h60
`define FBC_C_LOCK_SET   8'h01
`define FBC_C_PERM_SET   8'hF1
// timing
`define FBC_CLK_PS       8000
`define FBC_RESET_NS     100
`define FBC_STROBE_NS    50
`define FBC_RESET_CYC    ((`FBC_RESET_NS * 1000 + `FBC_CLK_PS - 1) / `FBC_CLK_PS)
`define FBC_STROBE_CYC   ((`FBC_STROBE_NS * 1000 + `FBC_CLK_PS - 1) / `FBC_CLK_PS)
`endif

// ### fbc_pin_engine.sv
// pin engine: one read or write cycle on the flash pins
// assumes synchronous inputs
`timescale 1ns/1ps
`include "fbc_map.svh"
module fbc_pin_engine #(
    parameter int AW      = 20,
    parameter int DW      = 16,
    parameter int STB_CYC = `FBC_STROBE_CYC
) (
    input  wire logic   clk_sys,  // system clock
    input  wire logic   rst_n,    // async reset, low
    fbc_cyc_if.eng      cyc,      // cycle requests
    input  wire logic   wide,     // sixteen-bit transfers
    input  wire logic [DW-1:0] dq_in, // data pins in
    output logic        ce_n,     // chip select
    output logic        oe_n,     // output enable
    output logic        we_n,     // write strobe
    output logic [AW-1:0] a_out,  // address pins
    output logic [DW-1:0] dq_out, // data pins out
    output logic        dq_oe_n   // low drives
);
    import fbc_pkg::*;
    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fbc_eng_t;
    fbc_eng_t eng_q;
    logic [7:0] cnt_q;
    logic       is_wr_q;
    wire        cnt_end = (cnt_q == 8'(STB_CYC - 1));
    // narrow mode keeps the upper lanes at zero
    wire [DW-1:0] rd_mask = wide ? {DW{1'b1}} : DW'(8'hFF);

    // write cycles: we_n rises before ce_n so the device latches on we_n
    // latch on first rising strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            eng_q    <= E_IDLE;
            cnt_q    <= 8'h00;
            is_wr_q  <= 1'b0;
            ce_n     <= 1'b1;
            oe_n     <= 1'b1;
            we_n     <= 1'b1;
            a_out    <= '0;
            dq_out   <= '0;
            dq_oe_n  <= 1'b1;
            cyc.done <= 1'b0;
            cyc.rdata <= '0;
        end else begin
            cyc.done <= 1'b0;
            unique case (eng_q)
                E_IDLE: if (cyc.req) begin
                    is_wr_q <= (cyc.kind == FBC_CYC_WRITE);
                    a_out   <= cyc.addr;
                    dq_out  <= cyc.wdata & rd_mask;
                    dq_oe_n <= (cyc.kind != FBC_CYC_WRITE);
                    ce_n    <= 1'b0;
                    eng_q   <= E_SETUP;
                end
                E_SETUP: begin
                    we_n  <= ~is_wr_q;
                    oe_n  <= is_wr_q;
                    cnt_q <= 8'h00;
                    eng_q <= E_STROBE;
                end
                E_STROBE: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_end) begin
                        we_n  <= 1'b1;
                        oe_n  <= 1'b1;
                        if (!is_wr_q)
                            cyc.rdata <= dq_in & rd_mask;
                        eng_q <= E_HOLD;
                    end
                end
                E_HOLD: begin
                    ce_n     <= 1'b1;
                    dq_oe_n  <= 1'b1;
                    cyc.done <= 1'b1;
                    eng_q    <= E_IDLE;
                end
            endcase
        end
    end
endmodule

// ### fbc_pkg.sv
// types for the flash bus controller
// assumes fbc_map.svh beside it
`include "fbc_map.svh"
package fbc_pkg;
    // operations software can order
    typedef enum logic [3:0] {
        FBC_OP_READ_ARRAY,
        FBC_OP_READ_ID,
        FBC_OP_READ_STAT,
        FBC_OP_CLR_STAT,
        FBC_OP_BLOCK_ERASE,
        FBC_OP_CHIP_ERASE,
        FBC_OP_PROGRAM,
        FBC_OP_SUSPEND,
        FBC_OP_RESUME,
        FBC_OP_LOCK_SET,
        FBC_OP_LOCK_CLR,
        FBC_OP_PERM_SET,
        FBC_OP_READ
    } fbc_op_t;
    // bus cycle kind for the pin engine
    typedef enum logic [1:0] {
        FBC_CYC_WRITE,
        FBC_CYC_READ
    } fbc_cyc_t;
endpackage
